//--- design/wlam_core.sv
`timescale 1ns/10ps

// How it works
// [RULE_01] Aligned load address is base plus sign-extended 16-bit displacement.
// [RULE_02] Aligned load writes the word; 64-bit mode sign-extends from bit 31.
// [RULE_03] Aligned load with nonzero low two address bits faults and is not performed.
// [RULE_04] All three loads report refill, invalid, bus and address errors.
// [RULE_05] Opcode 100011 is the aligned load; base, target, displacement fields.
// [RULE_06] Opcode 100010 is the left partial load with the same fields.
// [RULE_07] Opcode 100110 is the right partial load with the same fields.
// [RULE_08] Partial loads address any byte, no alignment needed.
// [RULE_09] Partial loads touch only the word holding the start byte.
// [RULE_10] Partial loads move one to four bytes by start position.
// [RULE_11] Left load puts start byte at top of low word, moving downward.
// [RULE_12] Left load keeps the uncovered low-order register bytes.
// [RULE_13] Right load puts start byte at bottom, moving toward word top.
// [RULE_14] Right load keeps the uncovered high-order bytes of the low word.
// [RULE_15] Left and right loads together assemble four unaligned bytes.
// [RULE_16] Target register is bypassed so back-to-back loads need no gap.
// [RULE_17] Partial loads never take misalignment address errors.
// [RULE_18] Little-endian left load sends access type equal to low two bits.
// [RULE_19] Little-endian left load clears low two physical address bits.
// [RULE_20] In 64-bit mode partial results sign-fill from merged bit 31.
// [RULE_21] Reversed byte order inverts the relevant low physical address bits.
module wlam_core (
	input  wire logic                       clock,
	input  wire logic                       reset,
	// Mode inputs
	input  wire logic                       mode64,
	input  wire logic                       memory_byte_order_flag,
	input  wire logic                       core_byte_order_flag,
	input  wire logic                       reversed_order_flag,
	// Instruction issue
	input  wire logic                       issueValid,
	output logic                            issueReady,
	input  wire logic [31:0]                instruction,
	input  wire logic [63:0]                baseValue,
	input  wire logic [63:0]                targetValue,
	// Memory request
	output logic                            memReqValid,
	output wlam_pkg::wlam_mem_req_type      memReq,
	// Memory response
	input  wire logic                       memRespValid,
	input  wire logic [31:0]                memRespData,
	input  wire logic                       tlbRefill,
	input  wire logic                       tlbInvalid,
	input  wire logic                       busError,
	input  wire logic                       addrFault,
	// Write back and exceptions
	output logic                            wbValid,
	output wlam_pkg::wlam_wb_type           wb,
	output logic                            excValid,
	output wlam_pkg::wlam_exc_type          exc,
	output logic                            unknownOp
);

	wlam_pkg::wlam_state_type   state_ff, nxt_state;
	wlam_pkg::wlam_kind_type    kind_ff, nxt_kind;
	logic [1:0]                 byteSel_ff, nxt_byteSel;
	logic [63:0]                oldValue_ff, nxt_oldValue;
	logic [4:0]                 target_ff, nxt_target;
	logic                       memReqValid_ff, nxt_memReqValid;
	wlam_pkg::wlam_mem_req_type memReq_ff, nxt_memReq;
	logic                       wbValid_ff, nxt_wbValid;
	wlam_pkg::wlam_wb_type      wb_ff, nxt_wb;
	logic                       excValid_ff, nxt_excValid;
	wlam_pkg::wlam_exc_type     exc_ff, nxt_exc;
	logic                       unknownOp_ff, nxt_unknownOp;
	logic                       wbHeld_ff, nxt_wbHeld;

	wlam_pkg::wlam_kind_type decKind;
	logic [5:0]              opcode;
	logic [4:0]              baseIdx;
	logic [4:0]              targetIdx;
	logic [63:0]             virtual_addr;
	logic [63:0]             mergeOld;
	logic [63:0]             mergeResult;
	logic [1:0]              laneSel;
	logic [2:0]              offsetBits;
	logic [2:0]              typeBits;
	logic                    misaligned;

	// Field extraction and opcode decode
	always_comb begin
		opcode    = instruction[wlam_pkg::OPCODE_MSB:wlam_pkg::OPCODE_LSB];
		baseIdx   = instruction[wlam_pkg::BASE_MSB:wlam_pkg::BASE_LSB];
		targetIdx = instruction[wlam_pkg::TARGET_MSB:wlam_pkg::TARGET_LSB];
		unique case (opcode)
			// [RULE_05] aligned load opcode
			wlam_pkg::OP_ALIGNED_WORD_LOAD:       decKind = wlam_pkg::WLAM_ALIGNED;
			// [RULE_06] left load opcode
			wlam_pkg::OP_LEFT_PARTIAL_WORD_LOAD:  decKind = wlam_pkg::WLAM_LEFT;
			// [RULE_07] right load opcode
			wlam_pkg::OP_RIGHT_PARTIAL_WORD_LOAD: decKind = wlam_pkg::WLAM_RIGHT;
			default:                              decKind = wlam_pkg::WLAM_NONE;
		endcase
	end

	// Effective address; base index is decoded by the register file outside
	// [RULE_01] sign-extended displacement
	// [RULE_08] any byte for partials
	assign virtual_addr = baseValue + {{(wlam_pkg::XLEN - wlam_pkg::DISP_BITS){instruction[wlam_pkg::DISP_MSB]}},
		instruction[wlam_pkg::DISP_MSB:0]};

	// Byte lane within the word, flipped for a big-endian core
	assign laneSel = virtual_addr[1:0] ^ {2{core_byte_order_flag}};

	// Access type and offset sent to memory
	always_comb begin
		typeBits   = wlam_pkg::ACCESS_WORD;
		offsetBits = virtual_addr[2:0];
		// [RULE_21] reversed order flip
		if (decKind == wlam_pkg::WLAM_ALIGNED) begin
			offsetBits = virtual_addr[2:0] ^ {reversed_order_flag, 2'h0};
		end else begin
			offsetBits = virtual_addr[2:0] ^ {3{reversed_order_flag}};
		end
		if (decKind == wlam_pkg::WLAM_LEFT) begin
			// [RULE_18] type follows start byte
			typeBits = {1'b0, laneSel};
			// [RULE_19] force word offset
			if (!memory_byte_order_flag) begin
				offsetBits = {offsetBits[2], 2'h0};
			end
		end else if (decKind == wlam_pkg::WLAM_RIGHT) begin
			// [RULE_10] one to four bytes
			typeBits = wlam_pkg::ACCESS_WORD - {1'b0, laneSel};
			// [RULE_09] same word only
			if (memory_byte_order_flag) begin
				offsetBits = 3'h0;
			end
		end
	end

	// [RULE_03] aligned only; [RULE_17] partials never misalign
	assign misaligned = (decKind == wlam_pkg::WLAM_ALIGNED) && (virtual_addr[1:0] != 2'h0);

	// Merge base was already bypassed at issue; the write back pulse is over by the answer
	assign mergeOld = oldValue_ff;

	wlam_merge u_merge (
		.kind     (kind_ff),
		.byteSel  (byteSel_ff),
		.mode64   (mode64),
		.memWord  (memRespData),
		.oldValue (mergeOld),
		.result   (mergeResult)
	);

	assign issueReady = (state_ff == wlam_pkg::WLAM_IDLE);

	// Sequencing: issue, wait for memory, write back or fault
	always_comb begin
		nxt_state       = state_ff;
		nxt_kind        = kind_ff;
		nxt_byteSel     = byteSel_ff;
		nxt_oldValue    = oldValue_ff;
		nxt_target      = target_ff;
		nxt_memReqValid = 1'b0;
		nxt_memReq      = memReq_ff;
		nxt_wbValid     = 1'b0;
		nxt_wb          = wb_ff;
		nxt_excValid    = 1'b0;
		nxt_exc         = exc_ff;
		nxt_unknownOp   = 1'b0;
		nxt_wbHeld      = wbHeld_ff;
		unique case (state_ff)
			wlam_pkg::WLAM_IDLE: begin
				if (issueValid) begin
					if (decKind == wlam_pkg::WLAM_NONE) begin
						nxt_unknownOp = 1'b1;
					end else if (misaligned) begin
						// [RULE_03] fault, no access issued
						nxt_excValid = 1'b1;
						nxt_exc      = '{tlbRefill: 1'b0, tlbInvalid: 1'b0, busError: 1'b0, addressError: 1'b1};
					end else begin
						nxt_kind        = decKind;
						nxt_byteSel     = laneSel;
						nxt_target      = targetIdx;
						// [RULE_16] bypass the last result written
						// The write back pulse ends before the next issue, so a held flag marks wb as live
						if (wbHeld_ff && wb_ff.targetRegister == targetIdx) begin
							nxt_oldValue = wb_ff.data;
						end else begin
							nxt_oldValue = targetValue;
						end
						nxt_memReqValid = 1'b1;
						nxt_memReq      = '{virtualAddr: virtual_addr, accessType: typeBits,
							byteOffset: offsetBits, reversedOrder: reversed_order_flag};
						nxt_state       = wlam_pkg::WLAM_WAIT;
					end
				end
			end
			wlam_pkg::WLAM_WAIT: begin
				if (memRespValid) begin
					nxt_state = wlam_pkg::WLAM_DONE;
					// [RULE_04] all four fault kinds
					if (tlbRefill || tlbInvalid || busError || addrFault) begin
						nxt_excValid = 1'b1;
						nxt_exc      = '{tlbRefill: tlbRefill, tlbInvalid: tlbInvalid,
							busError: busError, addressError: addrFault};
					end else begin
						// [RULE_15] merge result written
						nxt_wbValid = 1'b1;
						nxt_wb      = '{targetRegister: target_ff, data: mergeResult};
						nxt_wbHeld  = 1'b1;
					end
				end
			end
			wlam_pkg::WLAM_DONE: begin
				nxt_state = wlam_pkg::WLAM_IDLE;
			end
			default: nxt_state = wlam_pkg::WLAM_IDLE;
		endcase
	end

	// Registers only
	always_ff @(posedge clock) begin
		if (reset) begin
			state_ff       <= wlam_pkg::WLAM_IDLE;
			kind_ff        <= wlam_pkg::WLAM_NONE;
			byteSel_ff     <= 2'h0;
			oldValue_ff    <= 64'h0;
			target_ff      <= 5'h0;
			memReqValid_ff <= 1'b0;
			memReq_ff      <= '0;
			wbValid_ff     <= 1'b0;
			wb_ff          <= '0;
			excValid_ff    <= 1'b0;
			exc_ff         <= '0;
			unknownOp_ff   <= 1'b0;
			wbHeld_ff      <= 1'b0;
		end else begin
			state_ff       <= nxt_state;
			kind_ff        <= nxt_kind;
			byteSel_ff     <= nxt_byteSel;
			oldValue_ff    <= nxt_oldValue;
			target_ff      <= nxt_target;
			memReqValid_ff <= nxt_memReqValid;
			memReq_ff      <= nxt_memReq;
			wbValid_ff     <= nxt_wbValid;
			wb_ff          <= nxt_wb;
			excValid_ff    <= nxt_excValid;
			exc_ff         <= nxt_exc;
			unknownOp_ff   <= nxt_unknownOp;
			wbHeld_ff      <= nxt_wbHeld;
		end
	end

	assign memReqValid = memReqValid_ff;
	assign memReq      = memReq_ff;
	assign wbValid     = wbValid_ff;
	assign wb          = wb_ff;
	assign excValid    = excValid_ff;
	assign exc         = exc_ff;
	assign unknownOp   = unknownOp_ff;

endmodule

//--- design/wlam_pkg.sv
package wlam_pkg;

	// Primary opcodes of the three word loads
	localparam logic [5:0] OP_ALIGNED_WORD_LOAD       = 6'h23;
	localparam logic [5:0] OP_LEFT_PARTIAL_WORD_LOAD  = 6'h22;
	localparam logic [5:0] OP_RIGHT_PARTIAL_WORD_LOAD = 6'h26;

	// Instruction field positions
	localparam int OPCODE_MSB = 31;
	localparam int OPCODE_LSB = 26;
	localparam int BASE_MSB   = 25;
	localparam int BASE_LSB   = 21;
	localparam int TARGET_MSB = 20;
	localparam int TARGET_LSB = 16;
	localparam int DISP_MSB   = 15;

	// Widths
	localparam int XLEN      = 64;
	localparam int WORD_BITS = 32;
	localparam int DISP_BITS = 16;

	// Access type that loads the whole word
	localparam logic [2:0] ACCESS_WORD = 3'h3;

	// Load kinds
	typedef enum logic [1:0] {
		WLAM_NONE,
		WLAM_ALIGNED,
		WLAM_LEFT,
		WLAM_RIGHT
	} wlam_kind_type;

	// Pipeline states
	typedef enum logic [1:0] {
		WLAM_IDLE,
		WLAM_WAIT,
		WLAM_DONE
	} wlam_state_type;

	// Request issued to translation and memory
	typedef struct packed {
		logic [63:0] virtualAddr;
		logic [2:0]  accessType;
		logic [2:0]  byteOffset;
		logic        reversedOrder;
	} wlam_mem_req_type;

	// Exception flags reported with the result
	typedef struct packed {
		logic tlbRefill;
		logic tlbInvalid;
		logic busError;
		logic addressError;
	} wlam_exc_type;

	// Register file write back
	typedef struct packed {
		logic [4:0]  targetRegister;
		logic [63:0] data;
	} wlam_wb_type;

endpackage

//--- design/wlam_merge.sv
`timescale 1ns/10ps

// Merges memory bytes into the old register word for the three load kinds
module wlam_merge (
	// Selection
	input  wire wlam_pkg::wlam_kind_type kind,
	input  wire logic [1:0]              byteSel,
	input  wire logic                    mode64,
	// Data
	input  wire logic [31:0]             memWord,
	input  wire logic [63:0]             oldValue,
	// Result
	output logic [63:0]                  result
);

	logic [31:0] merged;

	// Byte lane merge, little-endian core order
	always_comb begin
		merged = memWord;
		unique case (kind)
			wlam_pkg::WLAM_LEFT: begin
				// [RULE_11] start byte to top
				// [RULE_12] low bytes kept
				merged = (memWord << (5'(3 - byteSel) * 5'd8)) |
					(oldValue[31:0] & ~(32'hFFFFFFFF << (5'(3 - byteSel) * 5'd8)));
			end
			wlam_pkg::WLAM_RIGHT: begin
				// [RULE_13] start byte to bottom
				// [RULE_14] high bytes kept
				merged = (memWord >> (5'(byteSel) * 5'd8)) |
					(oldValue[31:0] & ~(32'hFFFFFFFF >> (5'(byteSel) * 5'd8)));
			end
			default: merged = memWord;
		endcase
		// [RULE_02] [RULE_20] sign fill upper half
		if (mode64) begin
			result = {{32{merged[31]}}, merged};
		end else begin
			result = {oldValue[63:32], merged};
		end
	end

endmodule

//--- bench/wlam_mem_model.sv
`timescale 1ns/10ps

// Translation and memory stand-in: answers after a set delay, faults on command
module wlam_mem_model (
	// Clock and reset
	input wire logic	clock,
	input wire logic	reset,
	// Request and bench controls
	input wire logic	memReqValid,
	input wire wlam_pkg::wlam_mem_req_type	memReq,
	input wire logic [1:0]	respDelay,
	input wire logic [3:0]	faultSel,
	// Response
	output logic	memRespValid,
	output logic [31:0]	memRespData,
	output logic	tlbRefill,
	output logic	tlbInvalid,
	output logic	busError,
	output logic	addrFault
);
	logic	pend_ff;
	logic [1:0]	cnt_ff;
	logic [63:0]	addr_ff;
	logic [31:0]	junk_ff;

	function automatic logic [31:0] word_at(input logic [63:0] a);
		return {a[31:2], 2'h0} ^ 32'h5A3C96E1;
	endfunction

	// Idle lines churn every cycle so stale data is never mistaken for an answer
	assign memRespData = memRespValid ? word_at(addr_ff) : junk_ff;
	assign {tlbRefill, tlbInvalid, busError, addrFault} = memRespValid ? faultSel : junk_ff[7:4];

	// Response timing
	always_ff @(posedge clock) begin
		memRespValid <= 1'b0;
		junk_ff <= junk_ff + 32'h9E3779B9;
		if (reset) begin
			pend_ff <= 1'b0;
			junk_ff <= 32'h13579BDF;
		end else if (memReqValid) begin
			addr_ff <= memReq.virtualAddr;
			cnt_ff <= respDelay;
			pend_ff <= respDelay != 2'h0;
			memRespValid <= respDelay == 2'h0;
		end else if (pend_ff) begin
			cnt_ff <= cnt_ff - 2'h1;
			pend_ff <= cnt_ff != 2'h1;
			memRespValid <= cnt_ff == 2'h1;
		end
	end
endmodule

//--- bench/wlam_core_props.sv
`timescale 1ns/10ps

// Port-level checks of the word load datapath
module wlam_core_props (
	// Clock, reset and modes
	input wire logic	clock,
	input wire logic	reset,
	input wire logic	mode64,
	input wire logic	memory_byte_order_flag,
	input wire logic	core_byte_order_flag,
	input wire logic	reversed_order_flag,
	// Issue
	input wire logic	issueValid,
	input wire logic	issueReady,
	input wire logic [31:0]	instruction,
	input wire logic [63:0]	baseValue,
	// Memory
	input wire logic	memReqValid,
	input wire wlam_pkg::wlam_mem_req_type	memReq,
	input wire logic	memRespValid,
	input wire logic	tlbRefill,
	input wire logic	tlbInvalid,
	input wire logic	busError,
	input wire logic	addrFault,
	// Results
	input wire logic	wbValid,
	input wire wlam_pkg::wlam_wb_type	wb,
	input wire logic	excValid,
	input wire wlam_pkg::wlam_exc_type	exc,
	input wire logic	unknownOp
);
	logic [63:0]	ea;
	logic [2:0]	lo3;
	logic [3:0]	flt;
	logic	take;
	logic	isAl;
	logic	isLf;
	logic	isRt;

	// Effective address and decode of the offered word
	assign ea = baseValue + {{48{instruction[15]}}, instruction[15:0]};
	assign lo3 = ea[2:0];
	assign flt = {tlbRefill, tlbInvalid, busError, addrFault};
	assign take = issueValid && issueReady;
	assign isAl = instruction[31:26] == wlam_pkg::OP_ALIGNED_WORD_LOAD;
	assign isLf = instruction[31:26] == wlam_pkg::OP_LEFT_PARTIAL_WORD_LOAD;
	assign isRt = instruction[31:26] == wlam_pkg::OP_RIGHT_PARTIAL_WORD_LOAD;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	property p_aligned;
		take && isAl && lo3[1:0] == 2'h0 |=> memReqValid && memReq.virtualAddr == $past(ea)
			&& memReq.accessType == wlam_pkg::ACCESS_WORD;
	endproperty
	a_aligned: assert property (p_aligned) else $error("bad aligned request");
	property p_misaligned;
		take && isAl && lo3[1:0] != 2'h0 |=> excValid && exc.addressError && !memReqValid;
	endproperty
	a_misaligned: assert property (p_misaligned) else $error("misaligned load not refused");
	property p_partial;
		take && (isLf || isRt) |=> memReqValid && !excValid && memReq.virtualAddr == $past(ea);
	endproperty
	a_partial: assert property (p_partial) else $error("bad partial request");
	property p_left;
		take && isLf && !memory_byte_order_flag && !core_byte_order_flag && !reversed_order_flag |=>
			memReq.accessType == ($past(lo3) & 3'h3) && memReq.byteOffset == ($past(lo3) & 3'h4);
	endproperty
	a_left: assert property (p_left) else $error("bad left type or offset");
	property p_right;
		take && isRt && !memory_byte_order_flag |=>
			memReq.byteOffset == ($past(lo3) ^ {3{$past(reversed_order_flag)}});
	endproperty
	a_right: assert property (p_right) else $error("bad right offset");
	property p_unknown;
		take && !isAl && !isLf && !isRt |=> unknownOp && !memReqValid;
	endproperty
	a_unknown: assert property (p_unknown) else $error("unknown opcode not flagged");
	property p_fault;
		memRespValid && flt != 4'h0 |=> excValid && !wbValid && exc == $past(flt);
	endproperty
	a_fault: assert property (p_fault) else $error("fault not reported");
	property p_wb;
		memRespValid && flt == 4'h0 |=> wbValid && !excValid;
	endproperty
	a_wb: assert property (p_wb) else $error("missing write back");
	property p_fill;
		wbValid && mode64 |-> wb.data[63:32] == {32{wb.data[31]}};
	endproperty
	a_fill: assert property (p_fill) else $error("upper half not sign filled");

	// Main scenarios reached
	c_left: cover property (take && isLf);
	c_fault: cover property (excValid && exc.busError);
	c_unknown: cover property (unknownOp);
endmodule

bind wlam_core wlam_core_props i_wlam_core_props (.*);

//--- bench/wlam_core_bench.sv
`timescale 1ns/10ps

// Random and corner word loads against the memory stand-in
module wlam_core_bench;
	logic	clock, reset, mode64, memory_byte_order_flag, core_byte_order_flag, reversed_order_flag;
	logic	issueValid, issueReady, memReqValid, memRespValid, wbValid, excValid, unknownOp;
	logic	tlbRefill, tlbInvalid, busError, addrFault;
	logic [31:0]	instruction, memRespData, pair;
	logic [63:0]	baseValue, targetValue, base;
	logic [63:0]	regs [32];
	logic [1:0]	respDelay;
	logic [3:0]	faultSel;
	wlam_pkg::wlam_mem_req_type	memReq;
	wlam_pkg::wlam_wb_type	wb;
	wlam_pkg::wlam_exc_type	exc;
	int	errorCnt = 0;
	int	comparisons = 0;
	int	seed = 32'hB00B;
	int	lastTgt = -1;

	wlam_core i_wlam_core (.*);
	wlam_mem_model i_wlam_mem_model (.*);

	// Free running clock
	always #10 clock = ~clock;

	task automatic check(input string name, input logic [71:0] seen, input logic [71:0] want);
		comparisons++;
		if (seen !== want) begin
			errorCnt++;
			$display("MISMATCH %s expected %h seen %h", name, want, seen);
		end
	endtask

	task automatic give_verdict;
		$display("errors %0d comparisons %0d", errorCnt, comparisons);
		if (errorCnt == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Low word merge per load kind; 32-bit mode keeps the old upper half
	function automatic logic [63:0] merge(input int k, input logic [1:0] ln, input logic [31:0] mw,
			input logic [63:0] old);
		logic [31:0] lo;
		lo = k == 0 ? mw : k == 1 ? (mw << (24 - 8 * ln)) | (old[31:0] & (32'hFFFFFFFF >> (8 * ln + 8)))
			: (mw >> (8 * ln)) | (old[31:0] & ~(32'hFFFFFFFF >> (8 * ln)));
		return mode64 ? {{32{lo[31]}}, lo} : {old[63:32], lo};
	endfunction

	// Memory image of the stand-in: one word per aligned address
	function automatic logic [31:0] word_of(input logic [63:0] a);
		return {a[31:2], 2'h0} ^ 32'h5A3C96E1;
	endfunction

	// One load: kind 0 aligned, 1 left, 2 right, 3 unknown; stale target value when bypass is due
	task automatic run_op(input int k, input logic [63:0] a, input logic [4:0] tgt);
		logic [15:0] d;
		logic [1:0] ln;
		logic [2:0] acc;
		logic [2:0] off;
		logic mis;
		int n;
		d = 16'($random(seed));
		@(posedge clock);
		// Mode flags were set by non-blocking assignment before the call; read them only now
		ln = a[1:0] ^ {2{core_byte_order_flag}};
		acc = k == 0 ? wlam_pkg::ACCESS_WORD : k == 1 ? {1'b0, ln} : 3'h3 - {1'b0, ln};
		off = a[2:0] ^ (k == 0 ? {reversed_order_flag, 2'h0} : {3{reversed_order_flag}});
		if (k == 1 && !memory_byte_order_flag)
			off[1:0] = 2'h0;
		if (k == 2 && memory_byte_order_flag)
			off = 3'h0;
		mis = k == 0 && a[1:0] != 2'h0;
		issueValid <= 1'b1;
		instruction <= {k == 0 ? wlam_pkg::OP_ALIGNED_WORD_LOAD : k == 1 ? wlam_pkg::OP_LEFT_PARTIAL_WORD_LOAD
			: k == 2 ? wlam_pkg::OP_RIGHT_PARTIAL_WORD_LOAD : 6'h3F, 5'h4, tgt, d};
		baseValue <= a - {{48{d[15]}}, d};
		targetValue <= lastTgt == tgt ? ~regs[tgt] : regs[tgt];
		@(posedge clock);
		issueValid <= 1'b0;
		n = 0;
		// Unknown and misaligned answers pulse right after the issue edge, so look there first
		#1;
		while (!(wbValid || excValid || unknownOp) && n < 20) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n == 20) begin
			errorCnt++;
			give_verdict();
		end
		check("outcome", {wbValid, excValid, unknownOp}, k == 3 ? 3'h1 : mis || faultSel != 4'h0 ? 3'h2 : 3'h4);
		check("ready", issueReady, k == 3 || mis);
		if (mis)
			check("misaligned", exc, 4'h1);
		if (k < 3 && !mis)
			check("request", memReq, {a, acc, off, reversed_order_flag});
		if (k < 3 && !mis && faultSel != 4'h0)
			check("fault", exc, faultSel);
		if (wbValid)
			check("writeback", wb, {tgt, merge(k, ln, word_of(a), regs[tgt])});
		if (wbValid)
			regs[tgt] = merge(k, ln, word_of(a), regs[tgt]);
		lastTgt = wbValid ? int'(tgt) : -1;
	endtask

	// Reset, then every kind at every byte position, then unaligned pairs
	initial begin
		{clock, mode64, memory_byte_order_flag, core_byte_order_flag, reversed_order_flag, issueValid} = 6'h0;
		{instruction, baseValue, targetValue, respDelay, faultSel} = 166'h0;
		reset = 1'b1;
		for (int i = 0; i < 32; i++)
			regs[i] = {$random(seed), $random(seed)};
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		for (int i = 0; i < 96; i++) begin
			@(posedge clock);
			{mode64, core_byte_order_flag, memory_byte_order_flag, reversed_order_flag, respDelay} <= 6'($random(seed));
			faultSel <= i % 7 == 3 ? 4'h1 << (i % 4) : 4'h0;
			run_op(i % 4, {$random(seed), 29'($random(seed)), 3'(i / 4)}, 5'(i / 2 % 3 + 1));
		end
		for (int j = 1; j < 4; j++) begin
			@(posedge clock);
			{mode64, core_byte_order_flag, memory_byte_order_flag, reversed_order_flag, respDelay, faultSel} <= 10'h0;
			base = 64'h2000 + 64'(9 * j);
			pair = 32'({word_of(base + 64'h4), word_of(base)} >> (8 * base[1:0]));
			run_op(2, base, 5'h7);
			run_op(1, base + 64'h3, 5'h7);
			check("pair", wb.data[31:0], pair);
		end
		give_verdict();
	end
endmodule
